// ===== rtl/diag_pkg.sv
// Constants, types and record layout of the output module diagnostic record
package diag_pkg;

  // ****************************************
  // Access numbers
  // ****************************************
  localparam logic [7:0]  REC_FULL    = 8'h01;   // Record set, whole record
  localparam logic [7:0]  REC_HEAD    = 8'h00;   // Record set, first bytes only
  localparam logic [15:0] CAN_FULL    = 16'h2f01; // CANopen index, whole record
  localparam logic [15:0] CAN_HEAD    = 16'h2f00; // CANopen index, first bytes
  localparam logic [15:0] ECAT_INDEX  = 16'h5005; // EtherCAT object index
  localparam logic [7:0]  SX_FIRST    = 8'h02;   // Subindex of first byte item
  localparam logic [7:0]  SX_LAST     = 8'h11;   // Subindex of last byte item
  localparam logic [7:0]  SX_TICK     = 8'h13;   // Subindex of ticker snapshot

  // ****************************************
  // Record layout (lengths and byte positions)
  // ****************************************
  localparam int          REC_BYTES   = 20;      // Whole record length
  localparam logic [4:0]  LEN_FULL    = 5'h14;   // Whole record length, sized
  localparam logic [4:0]  LEN_HEAD    = 5'h04;   // Head part length
  localparam logic [4:0]  LEN_ITEM    = 5'h01;   // One byte item
  localparam logic [4:0]  LEN_TICK    = 5'h04;   // Ticker item length
  localparam logic [4:0]  POS_MODINFO = 5'h01;   // module_class_info
  localparam logic [4:0]  POS_CHKIND  = 5'h04;   // channel_kind
  localparam logic [4:0]  POS_DBITS   = 5'h05;   // diag_bits_per_channel
  localparam logic [4:0]  POS_CHCNT   = 5'h06;   // channel_count
  localparam logic [4:0]  POS_RESERVED_CHANNEL_ERROR   = 5'h08;   // First per-channel byte
  localparam int          NUM_RESERVED_CHANNEL_ERROR   = 8;       // Per-channel reserved bytes
  localparam logic [4:0]  POS_TICK    = 5'h10;   // First ticker byte (MSB)

  // ****************************************
  // Field values
  // ****************************************
  localparam logic [3:0]  MOD_CLASS_DIG = 4'hf;  // Digital module class
  localparam int          MOD_CHINFO_BIT = 4;    // Channel info present flag
  localparam logic [7:0]  MODINFO_RST = 8'h1f;   // module_class_info value
  localparam logic [6:0]  CHKIND_DO   = 7'h72;   // Digital output type
  localparam logic [7:0]  DBITS_RST   = 8'h00;   // No per-channel diag bits
  localparam logic [7:0]  CHCNT_RST   = 8'h04;   // Four output channels
  localparam logic [7:0]  RSVD_BYTE   = 8'h00;   // Reserved bytes read zero
  localparam logic [31:0] TICK_RST    = 32'h0000_0000; // Ticker reset value

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_NS      = 40;      // ref_clk period
  localparam int          TICK_NS     = 1000;    // One microsecond
  localparam int          TICK_DIV    = TICK_NS / CLK_NS; // Cycles per tick

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PATH_RECORD,                                 // CPU / fieldbus record set
    PATH_CANOPEN,                                // CANopen object index
    PATH_ETHERCAT                                // EtherCAT index/subindex
  } path_t;

  typedef struct packed {
    logic       write;                           // Write attempt
    path_t      path;                            // Access path
    logic [15:0] index;                          // Record number or index
    logic [7:0] sub;                             // EtherCAT subindex
    logic [4:0] offs;                            // Byte within the item
  } diag_req_t;

  typedef struct packed {
    logic       err;                             // Refused or unmapped
    logic [4:0] len;                             // Length of addressed item
    logic [7:0] data;                            // Returned byte
  } diag_rsp_t;

endpackage

// ===== rtl/tick_snapshot.sv
// Microsecond ticker with a coherent 32-bit snapshot register
`timescale 1ns/1ps
module tick_snapshot import diag_pkg::*; #(
  parameter int DIV = TICK_DIV                   // Clock cycles per microsecond
) (
  input  wire logic        ref_clk,              // 25 MHz clock
  input  wire logic        rst,                  // Async reset, active high
  input  wire logic        capture,              // Take a snapshot this edge
  output logic [31:0]      tick_now,             // Running ticker
  output logic [31:0]      snap                  // Held snapshot
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  pre_q, pre_d;                     // Prescaler
  logic [31:0] tick_q, tick_d;                   // Microsecond count
  logic [31:0] snap_q, snap_d;                   // Snapshot copy

  // Next values: prescaler wraps, ticker steps, snapshot on demand
  always_comb begin
    pre_d  = pre_q + 8'h01;
    tick_d = tick_q;
    snap_d = snap_q;
    if (pre_q == 8'(DIV - 1)) begin
      pre_d  = 8'h00;
      tick_d = tick_q + 32'h0000_0001;
    end
    // All 32 bits copied on one edge, never byte by byte
    if (capture) begin
      snap_d = tick_q;
    end
  end

  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q  <= 8'h00;
      tick_q <= TICK_RST;
      snap_q <= TICK_RST;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
      snap_q <= snap_d;
    end
  end

  assign tick_now = tick_q;
  assign snap     = snap_q;

endmodule

// ===== rtl/output_module_diag_record.sv
// Diagnostic record server of the four-channel digital output module
`timescale 1ns/1ps
module output_module_diag_record import diag_pkg::*; #(
  parameter logic [7:0] NUM_CHANNELS = CHCNT_RST, // Output channel count
  parameter int         DIV          = TICK_DIV   // Cycles per microsecond
) (
  input  wire logic      ref_clk,                // 25 MHz clock
  input  wire logic      rst,                    // Async reset, active high
  input  wire logic      req_valid,              // Request offered
  input  diag_req_t      req,                    // Request fields
  output logic           req_ready,              // Request taken when high
  output logic           rsp_valid,              // Answer present, one cycle
  output diag_rsp_t      rsp,                    // Answer fields
  output logic [31:0]    tick_now                // Running microsecond ticker
);

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,                                     // Waiting for a request
    ST_LOOKUP,                                   // Request settled, capture and fetch
    ST_REPLY                                     // Answer on the port
  } state_t;

  state_t      state_q, state_d;                 // Sequencer state
  diag_req_t   req_q, req_d;                     // Latched request
  diag_rsp_t   rsp_q, rsp_d;                     // Registered answer
  diag_rsp_t   rsp_fill;                         // Fetched answer

  // ****************************************
  // Decode wires
  // ****************************************
  logic        take;                             // Request accepted
  logic        capture;                          // Record generation event
  logic        hit;                              // Address maps to the record
  logic        full_item;                        // Whole record addressed
  logic [4:0]  base;                             // First record byte of item
  logic [4:0]  len;                              // Item length in bytes
  logic [4:0]  pos;                              // Record byte selected
  logic [31:0] snap;                             // Held ticker snapshot
  logic [31:0] snap_view;                        // Snapshot as the record shows it
  logic        refuse;                           // Write, unmapped or out of range
  logic [7:0]  rec [REC_BYTES];                  // Record image

  // ****************************************
  // Ticker and snapshot
  // ****************************************
  // Ticker runs freely; the snapshot follows capture
  tick_snapshot #(
    .DIV (DIV)
  ) u_tick (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .capture  (capture),
    .tick_now (tick_now),
    .snap     (snap)
  );

  // ****************************************
  // Record image
  // ****************************************

  // A generating read sees the sample taken on its own capture edge
  always_comb begin
    // Otherwise the sample held from the last generation
    snap_view = snap;
    if (capture) begin
      snap_view = tick_now;
    end
  end

  // Build each byte of the record from constants and the snapshot
  always_comb begin
    // Reserved bytes default to zero
    for (int i = 0; i < REC_BYTES; i++) begin
      rec[i] = RSVD_BYTE;
    end
    // Class nibble plus channel-info flag, upper bits reserved
    rec[POS_MODINFO]                 = {3'b000, 1'b1, MOD_CLASS_DIG};
    // Channel information flag
    rec[POS_MODINFO][MOD_CHINFO_BIT] = MODINFO_RST[MOD_CHINFO_BIT];
    // Channel type, top bit fixed low
    rec[POS_CHKIND] = {1'b0, CHKIND_DO};
    // No per-channel diagnostic bits
    rec[POS_DBITS]  = DBITS_RST;
    // Number of output channels
    rec[POS_CHCNT]  = NUM_CHANNELS;
    // Snapshot, most significant byte first
    rec[POS_TICK]        = snap_view[31:24];
    rec[POS_TICK + 5'd1] = snap_view[23:16];
    rec[POS_TICK + 5'd2] = snap_view[15:8];
    rec[POS_TICK + 5'd3] = snap_view[7:0];
  end

  // ****************************************
  // Address decode
  // ****************************************

  // Map path and number to an item of the record
  always_comb begin
    hit       = 1'b0;
    full_item = 1'b0;
    base      = 5'h00;
    len       = 5'h00;
    case (req_q.path)
      PATH_RECORD: begin
        // Record set numbers
        if (req_q.index[7:0] == REC_FULL && req_q.index[15:8] == 8'h00) begin
          // Whole record
          hit       = 1'b1;
          full_item = 1'b1;
          len       = LEN_FULL;
        end else if (req_q.index == {8'h00, REC_HEAD}) begin
          // First four bytes only
          hit = 1'b1;
          len = LEN_HEAD;
        end
      end
      PATH_CANOPEN: begin
        // CANopen object indices
        if (req_q.index == CAN_FULL) begin
          // Whole record
          hit       = 1'b1;
          full_item = 1'b1;
          len       = LEN_FULL;
        end else if (req_q.index == CAN_HEAD) begin
          // First four bytes only
          hit = 1'b1;
          len = LEN_HEAD;
        end
      end
      PATH_ETHERCAT: begin
        // One subindex per item under one object
        if (req_q.index == ECAT_INDEX) begin
          if (req_q.sub >= SX_FIRST && req_q.sub <= SX_LAST) begin
            // Single byte items
            hit  = 1'b1;
            base = 5'(req_q.sub - SX_FIRST);
            len  = LEN_ITEM;
          end else if (req_q.sub == SX_TICK) begin
            // Four-byte ticker item
            hit  = 1'b1;
            base = POS_TICK;
            len  = LEN_TICK;
          end
        end
      end
      default: begin
        // Unused path code
        hit = 1'b0;
      end
    endcase
  end

  // Byte within the record
  assign pos = base + req_q.offs;

  // ****************************************
  // Generation event
  // ****************************************

  // A read that starts the whole record or the ticker item generates it
  always_comb begin
    capture = 1'b0;
    if (state_q == ST_LOOKUP && !req_q.write && req_q.offs == 5'h00) begin
      // Only the opening byte of the whole record or the ticker item
      if (hit && (full_item || base == POS_TICK)) begin
        capture = 1'b1;
      end
    end
  end

  // ****************************************
  // Handshake
  // ****************************************

  // Taken only while idle; no alarm path exists, answers only follow requests
  assign req_ready = (state_q == ST_IDLE);
  assign take      = req_valid && req_ready;
  // Pulse only in the reply state
  assign rsp_valid = (state_q == ST_REPLY);
  // Answer straight from its register
  assign rsp       = rsp_q;

  // ****************************************
  // Sequencer next state
  // ****************************************

  // Idle, lookup, reply, back to idle
  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    case (state_q)
      ST_IDLE: begin
        // Latch the request
        if (take) begin
          req_d   = req;
          state_d = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        // Snapshot is taken on this edge, and the answer is loaded on the same edge
        state_d = ST_REPLY;
      end
      ST_REPLY: begin
        // Answer stands one cycle
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Refusal
  // ****************************************

  // Writes, unmapped numbers and bytes past the item end are refused
  always_comb begin
    refuse = 1'b0;
    if (req_q.write) begin
      // Every field is read-only; nothing is stored
      refuse = 1'b1;
    end else if (!hit) begin
      // Number or subindex outside the record
      refuse = 1'b1;
    end else if (req_q.offs >= len) begin
      // Byte beyond the end of the addressed item
      refuse = 1'b1;
    end
  end

  // ****************************************
  // Answer formation
  // ****************************************

  // Fetched answer; refused requests read zero, length still reported
  always_comb begin
    rsp_fill.err  = refuse;
    rsp_fill.len  = len;
    rsp_fill.data = RSVD_BYTE;
    if (!refuse) begin
      // In range: byte of the record image
      rsp_fill.data = rec[pos];
    end
  end

  // Next answer: loaded as lookup ends, held between pulses
  always_comb begin
    // Hold the last answer
    rsp_d = rsp_q;
    if (state_q == ST_LOOKUP) begin
      // Snapshot of this request already in the record image
      rsp_d = rsp_fill;
    end
  end

  // ****************************************
  // Registers
  // ****************************************

  // Sequencer and request latch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Idle with an empty request after reset
      state_q <= ST_IDLE;
      req_q   <= '0;
    end else begin
      // Next state and latched request
      state_q <= state_d;
      req_q   <= req_d;
    end
  end

  // Answer register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Empty answer after reset
      rsp_q <= '0;
    end else begin
      // Next answer or held value
      rsp_q <= rsp_d;
    end
  end

endmodule

// ===== verif/diag_record_properties.sv
// Port checks of the diagnostic record server
`timescale 1ns/1ps
module diag_record_properties import diag_pkg::*; (
  input logic        ref_clk,   // Clock
  input logic        rst,       // Reset
  input logic        req_valid, // Request offered
  input diag_req_t   req,       // Request fields
  input logic        req_ready, // Request taken
  input logic        rsp_valid, // Answer pulse
  input diag_rsp_t   rsp,       // Answer fields
  input logic [31:0] tick_now   // Ticker
);
  // ****************************************
  // Helpers
  // ****************************************
  wire take = req_valid && req_ready; // Request taken this edge
  wire ecat = take && !req.write && req.path == PATH_ETHERCAT && req.index == 16'h5005 && req.offs == 5'h00;
  wire head = (req.path == PATH_RECORD && req.index == 16'h0000) || (req.path == PATH_CANOPEN && req.index == 16'h2f00);
  wire full = (req.path == PATH_RECORD && req.index == 16'h0001) || (req.path == PATH_CANOPEN && req.index == 16'h2f01);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Checks
  // ****************************************
  chk_answer_on_request: assert property (rsp_valid |-> $past(take, 2))
    else $error("answer without request");
  chk_answer_latency: assert property (take |=> !rsp_valid ##1 rsp_valid ##1 !rsp_valid)
    else $error("answer timing wrong");
  chk_ready_gap: assert property (take |=> !req_ready [*2] ##1 req_ready)
    else $error("ready gap wrong");
  chk_full_len: assert property (take && !req.write && full && req.offs < 5'h14 |-> ##2 !rsp.err && rsp.len == 5'h14)
    else $error("whole record length wrong");
  chk_head_len: assert property (take && !req.write && head && req.offs < 5'h04 |-> ##2 !rsp.err && rsp.len == 5'h04)
    else $error("head length wrong");
  chk_tick_len: assert property (ecat && req.sub == 8'h13 |-> ##2 rsp.len == 5'h04 && !rsp.err)
    else $error("ticker item length wrong");
  chk_modinfo_value: assert property (ecat && req.sub == 8'h03 |-> ##2 rsp == {1'b0, 5'h01, 8'h1f})
    else $error("module info wrong");
  chk_kind_value: assert property (ecat && req.sub == 8'h06 |-> ##2 rsp.data == 8'h72 && !rsp.data[7])
    else $error("channel kind wrong");
  chk_count_value: assert property (ecat && req.sub == 8'h08 |-> ##2 rsp.data == 8'h04)
    else $error("channel count wrong");
  chk_write_refused: assert property (take && req.write |-> ##2 rsp.err && rsp.data == 8'h00)
    else $error("write not refused");
  chk_tick_step: assert property ($changed(tick_now) |-> tick_now == $past(tick_now) + 32'h1)
    else $error("ticker step wrong");
endmodule

// ===== verif/coupler_model.sv
// Head module model that issues diagnostic record requests
`timescale 1ns/1ps
module coupler_model import diag_pkg::*; (
  input  logic      ref_clk,   // Clock
  input  logic      req_ready, // Request taken when high
  output logic      req_valid, // Request offered
  output diag_req_t req        // Request fields
);
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Offer after gap + 1 idle cycles, hold until taken, then release
  task automatic issue(input diag_req_t r, input int gap);
    repeat (gap + 1) @(negedge ref_clk);
    req_valid = 1'b1;
    req = r;
    // Ready is looked at half a cycle before the edge, never in the edge's own step
    while (req_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    req = ~r; // Released fields never keep the last value
  endtask
endmodule

// ===== verif/tb_output_module_diag_record.sv
// Self-checking bench of the diagnostic record server
`timescale 1ns/1ps
module tb_output_module_diag_record import diag_pkg::*;;
  typedef struct packed { diag_rsp_t r; logic lk; } exp_t; // Expected answer, lk: length known
  logic        ref_clk = 1'b0;  // Clock
  logic        rst = 1'b1;      // Reset
  logic        req_valid;       // Request offered
  logic        req_ready;       // Request taken
  logic        rsp_valid;       // Answer pulse
  diag_req_t   req;             // Request fields
  diag_rsp_t   rsp;             // Answer fields
  logic [31:0] tick_now;        // Running ticker
  logic [31:0] snap = 32'h0;    // Expected held snapshot
  logic [7:0]  lfsr = 8'h3e;    // Random source
  logic [7:0]  rnd;             // Random draw
  exp_t        q[$];            // Pending expectations
  exp_t        me;              // Monitor entry
  int          errors = 0;      // Mismatches
  int          compares = 0;    // Comparisons
  int          cycles = 0;      // Run length
  path_t       ap[4] = '{PATH_RECORD, PATH_RECORD, PATH_CANOPEN, PATH_CANOPEN}; // Access table
  logic [15:0] ai[4] = '{16'h0001, 16'h0000, 16'h2f01, 16'h2f00};
  int          al[4] = '{20, 4, 20, 4};
  always #20 ref_clk = ~ref_clk;
  output_module_diag_record #(.DIV(2)) dut (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .tick_now(tick_now));
  coupler_model partner (.ref_clk(ref_clk), .req_ready(req_ready), .req_valid(req_valid), .req(req));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] next_rand();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  // Record byte by position
  function automatic logic [7:0] rec_byte(input logic [4:0] b);
    case (b)
      5'h01: return 8'h1f;
      5'h04: return 8'h72;
      5'h06: return 8'h04;
      5'h10, 5'h11, 5'h12, 5'h13: return 8'(snap >> (8 * (19 - int'(b))));
      default: return 8'h00;
    endcase
  endfunction
  // Expected answer of one request
  function automatic exp_t exp_of(input diag_req_t r);
    exp_t e;
    logic [4:0] b;
    e = '{r: '{err: 1'b1, len: 5'h00, data: 8'h00}, lk: 1'b1};
    b = r.offs;
    if (r.path == PATH_ETHERCAT && r.index == 16'h5005 && r.sub >= 8'h02 && r.sub <= 8'h11) begin
      e.r.len = 5'h01;
      b = r.sub[4:0] - 5'h02;
    end else if (r.path == PATH_ETHERCAT && r.index == 16'h5005 && r.sub == 8'h13) begin
      e.r.len = 5'h04;
      b = 5'h10 + r.offs;
    end else if ((r.path == PATH_RECORD && r.index == 16'h0001) || (r.path == PATH_CANOPEN && r.index == 16'h2f01)) begin
      e.r.len = 5'h14;
    end else if ((r.path == PATH_RECORD && r.index == 16'h0000) || (r.path == PATH_CANOPEN && r.index == 16'h2f00)) begin
      e.r.len = 5'h04;
    end else begin
      e.lk = 1'b0; // Unmapped: no item, length zero
    end
    if (e.lk && !r.write && r.offs < e.r.len) begin
      e.r.err = 1'b0;
      e.r.data = rec_byte(b);
    end
    return e;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // One request; a generating read takes the ticker seen before the capture edge
  task automatic rd(input path_t p, input logic [15:0] ix, input logic [7:0] sx, input logic [4:0] o,
                    input logic w, input int gap);
    diag_req_t r;
    exp_t e;
    r = '{write: w, path: p, index: ix, sub: sx, offs: o};
    e = exp_of(r);
    partner.issue(r, gap);
    if (!w && o == 5'h00 && e.lk && (e.r.len == 5'h14 || (p == PATH_ETHERCAT && sx == 8'h13))) begin
      snap = tick_now;
    end
    q.push_back(exp_of(r));
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      me = (q.size() > 0) ? q.pop_front() : '{r: '{err: 1'b1, len: 5'h1f, data: 8'hff}, lk: 1'b1};
      check(32'(rsp), 32'(me.r));
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge ref_clk);
    check(32'({req_ready, rsp_valid, rsp}), 32'h8000);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      for (int o = 0; o <= al[i]; o++) begin
        rd(ap[i], ai[i], 8'h00, 5'(o), 1'b0, 0);
      end
      rd(ap[i], ai[i], 8'h00, 5'h01, 1'b1, 0);
    end
    for (int s = 2; s <= 19; s++) begin
      rd(PATH_ETHERCAT, 16'h5005, 8'(s), 5'h00, 1'b0, 1);
    end
    for (int o = 1; o <= 4; o++) begin
      rd(PATH_ETHERCAT, 16'h5005, 8'h13, 5'(o), 1'b0, 0);
    end
    rd(PATH_ETHERCAT, 16'h5006, 8'h03, 5'h00, 1'b0, 0);
    repeat (24) begin
      rnd = next_rand();
      rd(PATH_ETHERCAT, 16'h5005, (rnd[4:0] == 5'h13) ? 8'h12 : {3'h0, rnd[4:0]}, {3'h0, rnd[6:5]},
         rnd[7], int'(rnd[1:0]));
    end
    repeat (4) @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    check(32'({req_ready, rsp_valid, rsp}), 32'h8000);
    check(tick_now, 32'h0);
    rst = 1'b0;
    rd(PATH_ETHERCAT, 16'h5005, 8'h08, 5'h00, 1'b0, 0);
    repeat (4) @(negedge ref_clk);
    check(32'(q.size()), 32'h0);
    summarize();
  end
endmodule

bind output_module_diag_record diag_record_properties chk (
  .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .tick_now(tick_now));
